// *** include/panel_pkg.sv ***
// Constants, codes and carrier types for the front-panel control block.
// Assumes a single clock domain; keys and straps arrive asynchronously on pins.
package panel_pkg;
  // ---------------------------------------------------------------
  // Register map and bus
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SET_W = 16;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_VSET = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ISET = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] REG_PROG = 8'h14;
  localparam logic [SET_W-1:0] SET_RST = 16'h0000;
  // ---------------------------------------------------------------
  // Pin vector layout
  // ---------------------------------------------------------------
  localparam int KEY_LOCAL = 0;
  localparam int KEY_OUTPUT = 1;
  localparam int KEY_MENU = 2;
  localparam int KEY_ENTER = 3;
  localparam int KEY_CLEAR = 4;
  localparam int KEY_UP = 5;
  localparam int KEY_DOWN = 6;
  localparam int KEY_DIG0 = 7;
  localparam int CC_SENSE = 17;
  localparam int PWRUP_OUT_ON = 18;
  localparam int SYNC_W = 19;
  // ---------------------------------------------------------------
  // Settings
  // ---------------------------------------------------------------
  localparam logic [3:0] CONTRAST_MIN = 4'h0;
  localparam logic [3:0] CONTRAST_MAX = 4'h9;
  localparam logic [3:0] CONTRAST_RST = 4'h5;
  localparam logic SPEAKER_RST = 1'b1;
  // ---------------------------------------------------------------
  // Interrupt status bits
  // ---------------------------------------------------------------
  localparam int IRQ_REMOTE = 0;
  localparam int IRQ_LOCAL = 1;
  localparam int IRQ_OUTPUT = 2;
  localparam int IRQ_FAULT = 3;
  localparam int IRQ_RECOVER = 4;
  localparam int IRQ_W = 5;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TOP_TEST = 4'h1, TOP_RETRY = 4'h2, TOP_RUN = 4'h4, TOP_FAIL = 4'h8
  } top_t;
  typedef enum logic [2:0] {
    MENU_NONE = 3'h1, MENU_CONTRAST = 3'h2, MENU_SPEAKER = 3'h4
  } menu_t;
  typedef enum logic [2:0] {
    no_fault = 3'h0, program_memory_fault = 3'h1, working_memory_fault = 3'h2,
    nonvolatile_pot_fault = 3'h3, nonvolatile_status_fault = 3'h4,
    page_check_fault = 3'h5, configuration_check_fault = 3'h6
  } fault_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic remote_ind;
    logic remote_locked_indicator;
    logic local_ind;
    logic top_off;
    logic constant_voltage_regulation;
    logic constant_current_regulation;
    logic bottom_measured;
    fault_t fault;
  } display_t;
  typedef struct packed {
    top_t top;
    menu_t menu;
    logic launched;
    logic boot;
    logic remote;
    logic locked;
    logic out_en;
    logic speaker_en;
    logic [3:0] contrast;
    fault_t fault;
    logic [SET_W-1:0] v_set;
    logic [SET_W-1:0] i_set;
    logic [SET_W-1:0] v_prog;
    logic [SET_W-1:0] i_prog;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
    logic test_start;
    logic beep;
  } state_t;
endpackage : panel_pkg

// *** core/pin_sync.sv ***
// Three-stage synchroniser with agreement filter and press detector per pin.
// Assumes pins are asynchronous to clock; rst_n is already synchronised.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] press
);
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  // ---------------------------------------------------------------
  // Per-pin stages
  // ---------------------------------------------------------------
  for (genvar g = 0; g < WIDTH; g++) begin : g_pin
    logic s1_r, s2_r, s3_r, lvl_r, prs_r;
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        lvl_r <= 1'b0;
        prs_r <= 1'b0;
      end else begin
        s1_r <= pins[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
        // Change counts only once two late stages agree
        if (s2_r == s3_r) begin
          lvl_r <= s3_r;
        end
        prs_r <= (s2_r == s3_r) && s3_r && !lvl_r;
      end
    end
    assign level[g] = lvl_r;
    assign press[g] = prs_r;
  end
endmodule : pin_sync

// *** core/panel_ctrl.sv ***
// Front-panel control: local/remote, lockout, contrast, speaker, output gate,
// self-test faults with retry. Assumes a register master on the same clock,
// keypad and strap pins asynchronous, remote commands as one-cycle pulses.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module panel_ctrl
  import panel_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire bus_req_t bus,
  output logic [DATA_W-1:0] rdata,
  output logic irq,
  input wire logic [SYNC_W-1:0] panel_pins,
  input wire logic cmd_remote,
  input wire logic cmd_lockout,
  input wire logic cmd_unlock,
  output logic test_start,
  input wire logic test_done,
  input wire logic test_pass,
  input wire fault_t test_fault,
  input wire logic op_fault,
  input wire fault_t op_fault_code,
  output display_t display,
  output logic [3:0] contrast,
  output logic speaker_en,
  output logic beep,
  output logic out_en,
  output logic [SET_W-1:0] v_prog,
  output logic [SET_W-1:0] i_prog
);
  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_a_r, rst_n;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_a_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n <= rst_a_r;
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] lvl, prs;
  pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pins(panel_pins),
    .level(lvl),
    .press(prs)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_t s, n;
  logic keys_ok, any_key, dig_hit;
  logic [3:0] dig;
  logic [IRQ_W-1:0] ev, w1c;

  always_comb begin
    n = s;
    n.test_start = 1'b0;
    n.rdata = '0;
    ev = '0;
    dig = 4'h0;
    dig_hit = 1'b0;
    for (int k = 0; k < 10; k++) begin
      if (prs[KEY_DIG0 + k]) begin
        dig = 4'(k);
        dig_hit = 1'b1;
      end
    end
    any_key = |prs[KEY_DIG0 + 9:KEY_LOCAL];
    keys_ok = (s.top == TOP_RUN) && !s.remote;

    // Remote and lockout
    // Lockout landing in the same cycle beats the local key
    if (s.remote && prs[KEY_LOCAL] && !s.locked && !cmd_lockout) begin
      n.remote = 1'b0;
      ev[IRQ_LOCAL] = 1'b1;
    end
    if (cmd_remote) begin
      n.remote = 1'b1;
      if (!s.remote) ev[IRQ_REMOTE] = 1'b1;
    end
    if (cmd_lockout && s.remote) begin
      n.locked = 1'b1;
    end
    if (cmd_unlock) begin
      n.locked = 1'b0;
    end
    if (n.remote) begin
      n.menu = MENU_NONE;
    end

    // Menus and output key, local only
    if (keys_ok) begin
      case (s.menu)
        MENU_NONE: begin
          if (prs[KEY_MENU]) n.menu = MENU_CONTRAST;
          if (prs[KEY_OUTPUT]) begin
            n.out_en = !s.out_en;
            ev[IRQ_OUTPUT] = 1'b1;
          end
        end
        MENU_CONTRAST: begin
          if (prs[KEY_UP] && s.contrast < CONTRAST_MAX) n.contrast = s.contrast + 4'h1;
          if (prs[KEY_DOWN] && s.contrast > CONTRAST_MIN) n.contrast = s.contrast - 4'h1;
          if (dig_hit) n.contrast = dig;
          if (prs[KEY_MENU]) n.menu = MENU_SPEAKER;
          if (prs[KEY_ENTER] || prs[KEY_CLEAR]) n.menu = MENU_NONE;
        end
        MENU_SPEAKER: begin
          if (prs[KEY_DIG0 + 1]) n.speaker_en = 1'b1;
          if (prs[KEY_DIG0]) n.speaker_en = 1'b0;
          if (prs[KEY_MENU] || prs[KEY_ENTER] || prs[KEY_CLEAR]) n.menu = MENU_NONE;
        end
        default: n.menu = MENU_NONE;
      endcase
    end

    // Self-test and retry
    case (s.top)
      TOP_TEST: begin
        if (!s.launched) begin
          n.launched = 1'b1;
          n.test_start = 1'b1;
        end else if (test_done && test_pass) begin
          n.top = TOP_RUN;
          n.boot = 1'b0;
          // Strap read once per boot, when the boot test passes here or on its retry
          n.out_en = lvl[PWRUP_OUT_ON];
        end else if (test_done) begin
          n.fault = test_fault;
          n.test_start = 1'b1;
          n.top = TOP_RETRY;
          ev[IRQ_FAULT] = 1'b1;
        end
      end
      TOP_RETRY: begin
        if (test_done && test_pass) begin
          n.fault = no_fault;
          n.top = TOP_RUN;
          n.boot = 1'b0;
          if (s.boot) n.out_en = lvl[PWRUP_OUT_ON];
          ev[IRQ_RECOVER] = 1'b1;
        end else if (test_done) begin
          n.top = TOP_FAIL;
        end
      end
      TOP_RUN: begin
        if (op_fault) begin
          n.fault = op_fault_code;
          n.test_start = 1'b1;
          n.top = TOP_RETRY;
          ev[IRQ_FAULT] = 1'b1;
        end
      end
      TOP_FAIL: n.top = TOP_FAIL;
      default: n.top = TOP_FAIL;
    endcase

    // Register writes; hardware set beats software clear
    w1c = '0;
    if (bus.wr) begin
      case (bus.addr)
        REG_VSET: n.v_set = bus.wdata[SET_W-1:0];
        REG_ISET: n.i_set = bus.wdata[SET_W-1:0];
        REG_IRQ_STAT: w1c = bus.wdata[IRQ_W-1:0];
        REG_IRQ_MASK: n.irq_mask = bus.wdata[IRQ_W-1:0];
        default: w1c = '0;
      endcase
    end
    n.irq_stat = (s.irq_stat & ~w1c) | ev;

    // Setpoints are held while off so re-enable restores them
    n.v_prog = n.out_en ? n.v_set : SET_RST;
    n.i_prog = n.out_en ? n.i_set : SET_RST;

    // Ordinary beep gated, failure beep always
    n.beep = (any_key && keys_ok && s.speaker_en) || (n.top == TOP_FAIL);

    if (bus.rd) begin
      case (bus.addr)
        REG_STATUS: n.rdata = {13'h0000, s.fault, s.contrast, s.menu, s.top,
                               s.boot, s.speaker_en, s.out_en, s.locked, s.remote};
        REG_VSET: n.rdata = {16'h0000, s.v_set};
        REG_ISET: n.rdata = {16'h0000, s.i_set};
        REG_IRQ_STAT: n.rdata = {27'h0000000, s.irq_stat};
        REG_IRQ_MASK: n.rdata = {27'h0000000, s.irq_mask};
        REG_PROG: n.rdata = {s.i_prog, s.v_prog};
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s.top <= TOP_TEST;
      s.menu <= MENU_NONE;
      s.launched <= 1'b0;
      s.boot <= 1'b1;
      s.remote <= 1'b0;
      s.locked <= 1'b0;
      s.out_en <= 1'b0;
      s.speaker_en <= SPEAKER_RST;
      s.contrast <= CONTRAST_RST;
      s.fault <= no_fault;
      s.v_set <= SET_RST;
      s.i_set <= SET_RST;
      s.v_prog <= SET_RST;
      s.i_prog <= SET_RST;
      s.irq_stat <= '0;
      s.irq_mask <= '0;
      s.rdata <= '0;
      s.test_start <= 1'b0;
      s.beep <= 1'b0;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata = s.rdata;
  assign irq = |(s.irq_stat & s.irq_mask);
  assign test_start = s.test_start;
  assign contrast = s.contrast;
  assign speaker_en = s.speaker_en;
  assign beep = s.beep;
  assign out_en = s.out_en;
  assign v_prog = s.v_prog;
  assign i_prog = s.i_prog;

  always_comb begin
    display.remote_ind = s.remote && !s.locked;
    display.remote_locked_indicator = s.locked;
    display.local_ind = !s.remote && !s.locked;
    display.top_off = !s.out_en;
    display.constant_voltage_regulation = s.out_en && !lvl[CC_SENSE];
    display.constant_current_regulation = s.out_en && lvl[CC_SENSE];
    display.bottom_measured = (s.top == TOP_RUN);
    display.fault = s.fault;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Checks sit on the released reset so the boot edges are not judged
  a_stay_local: assert property (!s.remote && !cmd_remote |=> !s.remote)
    else $error("left local without a remote command");
  a_remote_enter: assert property (
    cmd_remote |=> s.remote && (display.remote_ind || display.remote_locked_indicator))
    else $error("remote command did not enter remote");
  a_local_key: assert property (
    s.remote && !s.locked && prs[KEY_LOCAL] && !cmd_remote && !cmd_lockout |=> !s.remote)
    else $error("local key did not restore local");
  a_remote_ignore: assert property (
    s.remote && !cmd_unlock |=> $stable(s.contrast) && $stable(s.speaker_en)
    && ($stable(s.out_en) || $past(s.top) != TOP_RUN))
    else $error("key acted while in remote");
  a_lock_hold: assert property (s.locked && !cmd_unlock |=> s.locked && s.remote)
    else $error("lockout lost without unlock");
  a_lock_enter: assert property (cmd_lockout && s.remote && !cmd_unlock |=> s.locked)
    else $error("lockout command not taken in remote");
  a_lock_show: assert property (
    s.locked |-> display.remote_locked_indicator && !display.local_ind)
    else $error("locked indicator not shown");
  a_unlock_cause: assert property ($fell(s.locked) |-> $past(cmd_unlock))
    else $error("lockout cleared by other than unlock");
  a_unlock_clear: assert property (cmd_unlock |=> !s.locked)
    else $error("unlock command did not clear lockout");
  a_contrast_range: assert property (s.contrast <= CONTRAST_MAX)
    else $error("contrast out of range");
  a_contrast_step: assert property (
    keys_ok && s.menu == MENU_CONTRAST && prs[KEY_UP] && !prs[KEY_DOWN] && !dig_hit
    && s.contrast < CONTRAST_MAX |=> s.contrast == $past(s.contrast) + 4'h1)
    else $error("contrast did not step up");
  a_speaker_on: assert property (
    keys_ok && s.menu == MENU_SPEAKER && prs[KEY_DIG0 + 1] && !prs[KEY_DIG0] |=> s.speaker_en)
    else $error("speaker not enabled by digit one");
  a_speaker_off: assert property (
    keys_ok && s.menu == MENU_SPEAKER && prs[KEY_DIG0] |=> !s.speaker_en)
    else $error("speaker not disabled by digit zero");
  a_key_beep: assert property (keys_ok && any_key && s.speaker_en |=> beep)
    else $error("ordinary beep missing");
  a_quiet_keys: assert property (keys_ok && !s.speaker_en |=> !beep)
    else $error("ordinary beep sounded with speaker off");
  a_fail_beep: assert property (s.top == TOP_FAIL |-> ##1 beep [*2])
    else $error("failure beep missing");
  a_boot_strap: assert property (
    s.top == TOP_TEST && s.launched && test_done && test_pass
    |=> s.top == TOP_RUN && out_en == $past(lvl[PWRUP_OUT_ON]))
    else $error("power-up output does not follow strap");
  a_key_toggle: assert property (
    keys_ok && s.menu == MENU_NONE && prs[KEY_OUTPUT] |=> out_en != $past(s.out_en))
    else $error("output key did not toggle output");
  a_off_zero: assert property (
    !s.out_en |-> v_prog == SET_RST && i_prog == SET_RST && display.top_off)
    else $error("disabled output not zeroed");
  a_on_restore: assert property (s.out_en |-> v_prog == s.v_set && i_prog == s.i_set)
    else $error("setpoints not restored");
  // Fault code latched from the cycle of the report, not the scrambled lines after
  a_op_retry: assert property (
    s.top == TOP_RUN && op_fault
    |=> test_start && s.top == TOP_RETRY && s.fault == $past(op_fault_code))
    else $error("operation fault not retried");
  a_retry_start: assert property (
    s.top == TOP_TEST && s.launched && test_done && !test_pass
    |=> test_start && s.top == TOP_RETRY && s.fault == $past(test_fault))
    else $error("failed test not retried");
  a_retry_clear: assert property (
    s.top == TOP_RETRY && test_done && test_pass |=> s.fault == no_fault && s.top == TOP_RUN)
    else $error("retry pass did not clear fault");
  a_retry_fail: assert property (
    s.top == TOP_RETRY && test_done && !test_pass |=> s.top == TOP_FAIL)
    else $error("second failure did not stop");
endmodule : panel_ctrl

// *** verification/panel_far_side.sv ***
// Far-side model: keypad operator, remote controller and self-test engine.
// Assumes panel_ctrl on the same clock; outputs change just after a rising edge.
`timescale 1ns/100ps
module panel_far_side
  import panel_pkg::*;
(
  input wire logic clock,
  input wire logic test_start,
  output logic [SYNC_W-1:0] panel_pins,
  output logic cmd_remote,
  output logic cmd_lockout,
  output logic cmd_unlock,
  output logic test_done,
  output logic test_pass,
  output fault_t test_fault,
  output logic op_fault,
  output fault_t op_fault_code
);
  int fails_left = 0;
  int lat = 3;
  int wait_cnt = -1;
  fault_t fail_code = no_fault;
  initial begin
    panel_pins = '0;
    {cmd_remote, cmd_lockout, cmd_unlock, test_done, test_pass, op_fault} = 6'h00;
    test_fault = no_fault;
    op_fault_code = no_fault;
  end
  // ---------------------------------------------------------------
  // Self-test engine
  // ---------------------------------------------------------------
  // Result lines scrambled outside the done pulse so stale values never help
  always @(posedge clock) begin
    test_done <= 1'b0;
    if (test_start) begin
      wait_cnt <= lat;
    end else if (wait_cnt == 0) begin
      wait_cnt <= -1;
      test_done <= 1'b1;
      test_pass <= (fails_left == 0);
      test_fault <= (fails_left == 0) ? no_fault : fail_code;
      if (fails_left > 0) fails_left <= fails_left - 1;
    end else begin
      if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      test_pass <= ~test_pass;
      test_fault <= fault_t'(~test_fault);
    end
  end
  // ---------------------------------------------------------------
  // Operator and controller actions
  // ---------------------------------------------------------------
  // Hold and release longer than the pin filter needs
  task automatic press(input int k);
    @(posedge clock);
    panel_pins[k] <= 1'b1;
    repeat (8) @(posedge clock);
    panel_pins[k] <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
  endtask : press
  task automatic set_pin(input int k, input logic v);
    @(posedge clock);
    panel_pins[k] <= v;
  endtask : set_pin
  task automatic send(input int c);
    @(posedge clock);
    case (c)
      0: cmd_remote <= 1'b1;
      1: cmd_lockout <= 1'b1;
      default: cmd_unlock <= 1'b1;
    endcase
    @(posedge clock);
    {cmd_remote, cmd_lockout, cmd_unlock} <= 3'h0;
    repeat (2) @(posedge clock);
    #1;
  endtask : send
  task automatic raise(input fault_t code);
    @(posedge clock);
    op_fault <= 1'b1;
    op_fault_code <= code;
    @(posedge clock);
    op_fault <= 1'b0;
    op_fault_code <= fault_t'(~code);
    #1;
  endtask : raise
endmodule : panel_far_side

// *** verification/testbench.sv ***
// Self-checking bench for panel_ctrl driven through its register port and far side.
// Assumes panel_far_side plays keypad, remote controller and self-test engine.
`timescale 1ns/100ps
module testbench
  import panel_pkg::*;
;
  logic clock, rstn, irq, test_start, test_done, test_pass, op_fault, beep, out_en;
  logic cmd_remote, cmd_lockout, cmd_unlock, speaker_en;
  bus_req_t bus;
  logic [DATA_W-1:0] rdata, d;
  logic [SYNC_W-1:0] panel_pins;
  fault_t test_fault, op_fault_code;
  display_t display;
  logic [3:0] contrast;
  logic [SET_W-1:0] v_prog, i_prog;
  int err_count = 0;
  int cmp_count = 0;
  int i;

  panel_ctrl i_dut (.clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .irq(irq),
    .panel_pins(panel_pins), .cmd_remote(cmd_remote), .cmd_lockout(cmd_lockout),
    .cmd_unlock(cmd_unlock), .test_start(test_start), .test_done(test_done),
    .test_pass(test_pass), .test_fault(test_fault), .op_fault(op_fault),
    .op_fault_code(op_fault_code), .display(display), .contrast(contrast),
    .speaker_en(speaker_en), .beep(beep), .out_en(out_en), .v_prog(v_prog),
    .i_prog(i_prog));
  panel_far_side i_far (.clock(clock), .test_start(test_start), .panel_pins(panel_pins),
    .cmd_remote(cmd_remote), .cmd_lockout(cmd_lockout), .cmd_unlock(cmd_unlock),
    .test_done(test_done), .test_pass(test_pass), .test_fault(test_fault),
    .op_fault(op_fault), .op_fault_code(op_fault_code));

  always #4 clock = ~clock;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clock);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clock);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_rd
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    print_verdict();
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    bus = '0;
    i_far.fails_left = 1;
    i_far.fail_code = nonvolatile_pot_fault;
    // Strap set after the far side's own start-up so the two do not race
    i_far.set_pin(PWRUP_OUT_ON, 1'b1);
    settle(4);
    chk("local", 1, display.local_ind);
    chk("speaker", SPEAKER_RST, speaker_en);
    rstn <= 1'b1;
    for (i = 0; i < 40 && display.fault !== nonvolatile_pot_fault; i++) settle(1);
    chk("boot fault", nonvolatile_pot_fault, display.fault);
    for (i = 0; i < 40 && out_en !== 1'b1; i++) settle(1);
    chk("strap out", 1, out_en);
    chk("fault gone", no_fault, display.fault);
    chk("measured", 1, display.bottom_measured);
    reg_rd(REG_IRQ_STAT, d);
    chk("irq bits", 32'h18, d & 32'h18);
    reg_wr(REG_IRQ_MASK, 32'h18);
    chk("irq on", 1, irq);
    reg_wr(REG_IRQ_STAT, 32'h1F);
    reg_wr(REG_IRQ_MASK, 32'h04);
    chk("irq off", 0, irq);
    reg_rd(8'hFC, d);
    chk("unmapped", 0, d);
    reg_wr(REG_VSET, 32'h1234);
    reg_wr(REG_ISET, 32'h0567);
    reg_rd(REG_PROG, d);
    chk("prog", 32'h05671234, d);
    $display("test boot done");
    i_far.press(KEY_OUTPUT);
    chk("out off", 0, out_en);
    chk("v zero", 0, v_prog);
    chk("i zero", 0, i_prog);
    chk("off ind", 1, display.top_off);
    chk("meas off", 1, display.bottom_measured);
    chk("irq toggle", 1, irq);
    i_far.press(KEY_OUTPUT);
    chk("v back", 16'h1234, v_prog);
    chk("i back", 16'h0567, i_prog);
    chk("cv", 1, display.constant_voltage_regulation);
    i_far.set_pin(CC_SENSE, 1'b1);
    settle(10);
    chk("cc", 1, display.constant_current_regulation);
    i_far.set_pin(CC_SENSE, 1'b0);
    $display("test output done");
    i_far.press(KEY_MENU);
    for (i = 0; i < 5; i++) begin
      i_far.press(KEY_UP);
      chk("up", (i < 4) ? 6 + i : 9, contrast);
    end
    i_far.press(KEY_DIG0);
    chk("digit 0", CONTRAST_MIN, contrast);
    i_far.press(KEY_DOWN);
    chk("floor", CONTRAST_MIN, contrast);
    i_far.press(KEY_DIG0 + 7);
    chk("digit 7", 7, contrast);
    i_far.press(KEY_ENTER);
    reg_rd(REG_STATUS, d);
    chk("menu shut", 1, d[11:9]);
    i_far.press(KEY_MENU);
    i_far.press(KEY_MENU);
    i_far.press(KEY_DIG0);
    chk("spk 0", 0, speaker_en);
    i_far.press(KEY_DIG0 + 1);
    chk("spk 1", 1, speaker_en);
    i_far.press(KEY_DIG0);
    i_far.press(KEY_CLEAR);
    reg_rd(REG_STATUS, d);
    chk("spk menu", 1, d[11:9]);
    $display("test menus done");
    i_far.send(0);
    chk("remote", 1, display.remote_ind);
    i_far.press(KEY_OUTPUT);
    chk("key dead", 1, out_en);
    i_far.press(KEY_LOCAL);
    chk("local back", 1, display.local_ind);
    i_far.send(1);
    chk("lock local", 0, display.remote_locked_indicator);
    i_far.send(0);
    i_far.send(1);
    chk("locked ind", 1, display.remote_locked_indicator);
    chk("no loc ind", 0, display.local_ind);
    i_far.press(KEY_LOCAL);
    reg_rd(REG_STATUS, d);
    chk("still remote", 3, d[1:0]);
    i_far.send(2);
    chk("unlocked", 0, display.remote_locked_indicator);
    i_far.press(KEY_LOCAL);
    chk("local again", 1, display.local_ind);
    $display("test remote done");
    i_far.lat = 0;
    i_far.raise(program_memory_fault);
    chk("op fault", program_memory_fault, display.fault);
    settle(8);
    chk("op clear", no_fault, display.fault);
    reg_rd(REG_STATUS, d);
    chk("run", 4, d[8:5]);
    i_far.lat = 3;
    i_far.fails_left = 1;
    i_far.fail_code = page_check_fault;
    i_far.raise(working_memory_fault);
    settle(20);
    reg_rd(REG_STATUS, d);
    chk("fail", 8, d[8:5]);
    for (i = 0; i < 3; i++) begin
      settle(1);
      chk("fail beep", 1, beep & ~speaker_en);
    end
    $display("test faults done");
    print_verdict();
  end
endmodule : testbench
